/* File: shared/sfe_defines.vh */
// Constants for the serial flash erase controller: register map, field
// positions, reset values, flash opcodes and timing counts.
// Assumes inclusion by bare name from the controller's design files.
`ifndef SFE_DEFINES_VH
`define SFE_DEFINES_VH

`define SFE_REG_CTRL 8'h00
`define SFE_REG_ADDR 8'h04
`define SFE_REG_CFG 8'h08
`define SFE_REG_STAT 8'h0C

`define SFE_CTRL_GO 0
`define SFE_CTRL_OP_LO 1
`define SFE_CTRL_WIDE 3
`define SFE_CTRL_ALT 4
`define SFE_CFG_ADDR4 0
`define SFE_CFG_QUAD 1
`define SFE_STAT_BUSY 0
`define SFE_STAT_DONE 1
`define SFE_STAT_EOK 2
`define SFE_STAT_SR1_LO 8
`define SFE_STAT_SR2_LO 16
`define SFE_SR1_WIP 0
`define SFE_SR2_ESTAT 2

`define SFE_ADDR_RST 32'h0000_0000
`define SFE_CFG_RST 2'h0
`define SFE_STAT_RST 8'h00

`define SFE_OP_SMALL 2'h0
`define SFE_OP_SECTOR 2'h1
`define SFE_OP_WHOLE 2'h2
`define SFE_OP_EVAL 2'h3

`define SFE_OPC_WRITE_ENABLE_CMD 8'h06
`define SFE_OPC_SMALL 8'h20
`define SFE_OPC_SMALL_W 8'h21
`define SFE_OPC_SECT 8'hD8
`define SFE_OPC_SECT_W 8'hDC
`define SFE_OPC_WHOLE 8'h60
`define SFE_OPC_WHOLE_ALT 8'hC7
`define SFE_OPC_EVAL 8'hD0
`define SFE_OPC_READ_STATUS_ONE 8'h05
`define SFE_OPC_READ_STATUS_TWO 8'h07

`define SFE_SCK_HALF_CYC 16'd20
`define SFE_CS_GAP_CYC 8'd8

`endif

/* File: hw/sfe_spi_shift.v */
// Byte shifter for the flash link: makes the serial clock by dividing aclk
// and moves one byte per start, on one line or on four.
// Assumes the caller holds chip select and issues start only when idle.
`timescale 1ns/1ns
`include "sfe_defines.vh"
module sfe_spi_shift #(
  parameter [15:0] HALF = `SFE_SCK_HALF_CYC
) (
  input wire aclk, // System clock.
  input wire aresetn, // Synchronous reset, active low.
  input wire start, // One-cycle pulse: begin a byte.
  input wire [7:0] tx_byte, // Byte to send, MSB first.
  input wire quad, // One for four-line transfer.
  input wire rx_mode, // One to release all four data lines in quad mode; one-line transfers ignore it.
  output reg done, // One-cycle pulse at byte end.
  output reg [7:0] rx_byte, // Received byte.
  output reg sck, // Serial clock, idles low.
  output reg [3:0] io_out, // Data line drive values.
  output reg [3:0] io_oe_n, // Data line enables, low drives.
  input wire [3:0] io_in // Data line levels from the pins.
);
  reg busy_q;
  reg [15:0] div_q;
  reg [2:0] cnt_q;
  reg [7:0] sh_q;
  reg quad_q;
  reg [3:0] sync1_q;
  reg [3:0] sync2_q;

  always @(posedge aclk) begin
    sync1_q <= io_in;
    sync2_q <= sync1_q;
  end

  // Data change on the falling edge and the device samples on the rising
  // one; input is taken at the end of the high phase, long after the
  // device has driven it and after the two synchroniser stages.
  always @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= 1'b0;
      div_q <= 16'h0000;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      quad_q <= 1'b0;
      done <= 1'b0;
      rx_byte <= 8'h00;
      sck <= 1'b0;
      io_out <= 4'hC;
      io_oe_n <= 4'h2;
    end else begin
      done <= 1'b0;
      if (!busy_q) begin
        if (start) begin
          busy_q <= 1'b1;
          div_q <= 16'h0000;
          sh_q <= tx_byte;
          quad_q <= quad;
          if (quad) begin
            cnt_q <= 3'h1;
            io_out <= tx_byte[7:4];
            io_oe_n <= rx_mode ? 4'hF : 4'h0;
          end else begin
            cnt_q <= 3'h7;
            io_out <= {3'h6, tx_byte[7]};
            io_oe_n <= 4'h2;
          end
        end
      end else if (div_q == HALF - 16'd1) begin
        div_q <= 16'h0000;
        if (!sck) begin
          sck <= 1'b1;
        end else begin
          sck <= 1'b0;
          if (quad_q) begin
            rx_byte <= {rx_byte[3:0], sync2_q};
          end else begin
            rx_byte <= {rx_byte[6:0], sync2_q[1]};
          end
          if (cnt_q == 3'h0) begin
            busy_q <= 1'b0;
            done <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 3'h1;
            if (quad_q) begin
              sh_q <= {sh_q[3:0], 4'h0};
              io_out <= sh_q[3:0];
            end else begin
              sh_q <= {sh_q[6:0], 1'b0};
              io_out <= {3'h6, sh_q[6]};
            end
          end
        end
      end else begin
        div_q <= div_q + 16'd1;
      end
    end
  end
endmodule

/* File: hw/sfe_ctrl.v */
// Erase controller for a serial flash: software orders an erase or an
// erase status evaluation over AXI4-Lite, the controller runs the whole
// command sequence on the flash pins and reports the final first status byte, and the second status byte only after an evaluation.
// Assumes aclk at 250 MHz and a flash that answers in SPI mode 0.
`timescale 1ns/1ns
`include "sfe_defines.vh"
module sfe_ctrl #(
  parameter [15:0] SCK_HALF = `SFE_SCK_HALF_CYC,
  parameter [7:0] CS_GAP = `SFE_CS_GAP_CYC
) (
  input wire aclk, // System clock.
  input wire aresetn, // Synchronous reset, active low.
  input wire [7:0] s_axi_awaddr, // Write address.
  input wire s_axi_awvalid, // Write address valid.
  output reg s_axi_awready, // Write address ready.
  input wire [31:0] s_axi_wdata, // Write data.
  input wire [3:0] s_axi_wstrb, // Write byte strobes.
  input wire s_axi_wvalid, // Write data valid.
  output reg s_axi_wready, // Write data ready.
  output reg [1:0] s_axi_bresp, // Write response code.
  output reg s_axi_bvalid, // Write response valid.
  input wire s_axi_bready, // Write response ready.
  input wire [7:0] s_axi_araddr, // Read address.
  input wire s_axi_arvalid, // Read address valid.
  output reg s_axi_arready, // Read address ready.
  output reg [31:0] s_axi_rdata, // Read data.
  output reg [1:0] s_axi_rresp, // Read response code.
  output reg s_axi_rvalid, // Read data valid.
  input wire s_axi_rready, // Read data ready.
  output reg flash_cs_n, // Flash chip select, active low.
  output wire flash_sck, // Flash serial clock.
  output wire [3:0] flash_io_out, // Flash data line drive values.
  output wire [3:0] flash_io_oe_n, // Flash data line enables, low drives.
  input wire [3:0] flash_io_in // Flash data line levels.
);

  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_WRITE_ENABLE_CMD = 4'h1;
  localparam [3:0] S_CMD = 4'h2;
  localparam [3:0] S_ADDR = 4'h3;
  localparam [3:0] S_GAP = 4'h4;
  localparam [3:0] S_POLL = 4'h5;
  localparam [3:0] S_POLL_RD = 4'h6;
  localparam [3:0] S_SR2 = 4'h7;
  localparam [3:0] S_SR2_RD = 4'h8;

  // Software-visible state.
  reg [31:0] addr_q;
  reg [1:0] cfg_q;
  reg [4:1] ctrl_q;
  reg go_q;
  reg done_clr_q;
  reg done_q;
  reg eok_q;
  reg [7:0] sr1_q;
  reg [7:0] sr2_q;

  // Bus slave state.
  reg aw_have_q;
  reg w_have_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;

  // Sequencer state.
  reg [3:0] st_q;
  reg [3:0] gap_next_q;
  reg [7:0] gap_q;
  reg [1:0] abyte_q;
  reg [31:0] addr_sh_q;
  reg [1:0] op_q;
  reg quad_q;
  reg start_q;
  reg [7:0] tx_q;
  reg rx_mode_q;

  wire sh_done;
  wire [7:0] sh_rx;
  wire busy = (st_q != S_IDLE);
  wire wide = ctrl_q[`SFE_CTRL_WIDE];
  wire [1:0] op_w = ctrl_q[`SFE_CTRL_OP_LO + 1:`SFE_CTRL_OP_LO];
  wire [31:0] status_w = {8'h00, sr2_q, sr1_q, 5'h00, eok_q, done_q, busy};

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i * 8 +: 8] = nw[i * 8 +: 8];
        end
      end
    end
  endfunction

  function reg_hit;
    input [7:0] a;
    begin
      reg_hit = ({a[7:2], 2'b00} == `SFE_REG_CTRL) ||
                ({a[7:2], 2'b00} == `SFE_REG_ADDR) ||
                ({a[7:2], 2'b00} == `SFE_REG_CFG) ||
                ({a[7:2], 2'b00} == `SFE_REG_STAT);
    end
  endfunction

  // Write address and data are taken independently; the register update
  // and the response follow once both are held.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      addr_q <= `SFE_ADDR_RST;
      cfg_q <= `SFE_CFG_RST;
      ctrl_q <= 4'h0;
      go_q <= 1'b0;
      done_clr_q <= 1'b0;
    end else begin
      go_q <= 1'b0;
      done_clr_q <= 1'b0;
      if (s_axi_awready && s_axi_awvalid) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_have_q && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!w_have_q && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (aw_have_q && w_have_q && !s_axi_bvalid) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= reg_hit(awaddr_q) ? 2'b00 : 2'b10;
        case ({awaddr_q[7:2], 2'b00})
          `SFE_REG_CTRL: begin
            // A start while a sequence runs is dropped so that the
            // latched command cannot change under the sequencer.
            if (wstrb_q[0] && !busy) begin
              ctrl_q <= wdata_q[4:1];
              go_q <= wdata_q[`SFE_CTRL_GO];
            end
          end
          `SFE_REG_ADDR: addr_q <= merge(addr_q, wdata_q, wstrb_q);
          `SFE_REG_CFG: begin
            if (wstrb_q[0]) begin
              cfg_q <= wdata_q[1:0];
            end
          end
          `SFE_REG_STAT: begin
            if (wstrb_q[0] && wdata_q[`SFE_STAT_DONE]) begin
              done_clr_q <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= reg_hit(s_axi_araddr) ? 2'b00 : 2'b10;
        case ({s_axi_araddr[7:2], 2'b00})
          `SFE_REG_CTRL: s_axi_rdata <= {27'h000_0000, ctrl_q, 1'b0};
          `SFE_REG_ADDR: s_axi_rdata <= addr_q;
          `SFE_REG_CFG: s_axi_rdata <= {30'h0000_0000, cfg_q};
          `SFE_REG_STAT: s_axi_rdata <= status_w;
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Erase opcode for the latched command.
  function [7:0] erase_opc;
    input [1:0] op;
    input w;
    input alt;
    begin
      case (op)
        `SFE_OP_SMALL: erase_opc = w ? `SFE_OPC_SMALL_W : `SFE_OPC_SMALL;
        `SFE_OP_SECTOR: erase_opc = w ? `SFE_OPC_SECT_W : `SFE_OPC_SECT;
        `SFE_OP_WHOLE: erase_opc = alt ? `SFE_OPC_WHOLE_ALT : `SFE_OPC_WHOLE;
        default: erase_opc = `SFE_OPC_EVAL;
      endcase
    end
  endfunction

  wire four_byte = cfg_q[`SFE_CFG_ADDR4] ||
                   (wide && (op_w != `SFE_OP_EVAL));

  // Every flash command is its own chip-select frame with a gap of CS_GAP
  // cycles between frames. The erase frame ends the instant its last bit
  // is shifted, which is what makes the flash start the erase.
  always @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= S_IDLE;
      gap_next_q <= S_IDLE;
      gap_q <= 8'h00;
      abyte_q <= 2'h0;
      addr_sh_q <= 32'h0000_0000;
      op_q <= `SFE_OP_SMALL;
      quad_q <= 1'b0;
      start_q <= 1'b0;
      tx_q <= 8'h00;
      rx_mode_q <= 1'b0;
      flash_cs_n <= 1'b1;
      done_q <= 1'b0;
      eok_q <= 1'b0;
      sr1_q <= `SFE_STAT_RST;
      sr2_q <= `SFE_STAT_RST;
    end else begin
      start_q <= 1'b0;
      if (done_clr_q) begin
        done_q <= 1'b0;
      end
      case (st_q)
        S_IDLE: begin
          if (go_q) begin
            op_q <= op_w;
            quad_q <= cfg_q[`SFE_CFG_QUAD];
            addr_sh_q <= four_byte ? addr_q : {addr_q[23:0], 8'h00};
            abyte_q <= four_byte ? 2'h3 : 2'h2;
            tx_q <= erase_opc(op_w, wide, ctrl_q[`SFE_CTRL_ALT]);
            gap_q <= 8'h00;
            // The evaluate command sets its own latch and needs none.
            gap_next_q <= (op_w == `SFE_OP_EVAL) ? S_CMD : S_WRITE_ENABLE_CMD;
            st_q <= S_GAP;
          end
        end
        S_GAP: begin
          if (gap_q >= CS_GAP - 8'd1) begin
            flash_cs_n <= 1'b0;
            start_q <= 1'b1;
            rx_mode_q <= 1'b0;
            st_q <= gap_next_q;
            case (gap_next_q)
              S_WRITE_ENABLE_CMD: tx_q <= `SFE_OPC_WRITE_ENABLE_CMD;
              S_CMD: tx_q <= erase_opc(op_q, wide, ctrl_q[`SFE_CTRL_ALT]);
              S_POLL: tx_q <= `SFE_OPC_READ_STATUS_ONE;
              S_SR2: tx_q <= `SFE_OPC_READ_STATUS_TWO;
              default: tx_q <= 8'h00;
            endcase
          end else begin
            gap_q <= gap_q + 8'd1;
          end
        end
        S_WRITE_ENABLE_CMD: begin
          if (sh_done) begin
            flash_cs_n <= 1'b1;
            gap_q <= 8'h00;
            gap_next_q <= S_CMD;
            st_q <= S_GAP;
          end
        end
        S_CMD: begin
          if (sh_done) begin
            if (op_q == `SFE_OP_WHOLE) begin
              flash_cs_n <= 1'b1;
              gap_q <= 8'h00;
              gap_next_q <= S_POLL;
              st_q <= S_GAP;
            end else begin
              start_q <= 1'b1;
              tx_q <= addr_sh_q[31:24];
              addr_sh_q <= {addr_sh_q[23:0], 8'h00};
              st_q <= S_ADDR;
            end
          end
        end
        S_ADDR: begin
          if (sh_done) begin
            if (abyte_q == 2'h0) begin
              flash_cs_n <= 1'b1;
              gap_q <= 8'h00;
              gap_next_q <= S_POLL;
              st_q <= S_GAP;
            end else begin
              abyte_q <= abyte_q - 2'h1;
              start_q <= 1'b1;
              tx_q <= addr_sh_q[31:24];
              addr_sh_q <= {addr_sh_q[23:0], 8'h00};
            end
          end
        end
        S_POLL, S_SR2: begin
          if (sh_done) begin
            start_q <= 1'b1;
            tx_q <= 8'h00;
            rx_mode_q <= 1'b1;
            st_q <= (st_q == S_POLL) ? S_POLL_RD : S_SR2_RD;
          end
        end
        S_POLL_RD: begin
          if (sh_done) begin
            flash_cs_n <= 1'b1;
            sr1_q <= sh_rx;
            gap_q <= 8'h00;
            if (sh_rx[`SFE_SR1_WIP]) begin
              gap_next_q <= S_POLL;
              st_q <= S_GAP;
            end else if (op_q == `SFE_OP_EVAL) begin
              gap_next_q <= S_SR2;
              st_q <= S_GAP;
            end else begin
              done_q <= 1'b1;
              st_q <= S_IDLE;
            end
          end
        end
        S_SR2_RD: begin
          if (sh_done) begin
            flash_cs_n <= 1'b1;
            sr2_q <= sh_rx;
            // Software must erase again when this reads zero.
            eok_q <= sh_rx[`SFE_SR2_ESTAT];
            done_q <= 1'b1;
            st_q <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  sfe_spi_shift #(
    .HALF(SCK_HALF)
  ) u_shift (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(start_q),
    .tx_byte(tx_q),
    .quad(quad_q),
    .rx_mode(rx_mode_q),
    .done(sh_done),
    .rx_byte(sh_rx),
    .sck(flash_sck),
    .io_out(flash_io_out),
    .io_oe_n(flash_io_oe_n),
    .io_in(flash_io_in)
  );
endmodule

/* File: testbench/sfe_ctrl_sva.sv */
// Checker for sfe_ctrl: AXI answers and flash link framing.
// Assumes it is bound to sfe_ctrl and sees only its ports.
`timescale 1ns/1ns
module sfe_ctrl_chk #(
  parameter [15:0] SCK_HALF = 16'h0014,
  parameter [7:0] CS_GAP = 8'h08
) (
  input wire aclk, // Clock.
  input wire aresetn, // Reset, active low.
  input wire s_axi_awvalid, // Address valid.
  input wire s_axi_awready, // Address ready.
  input wire s_axi_wvalid, // Data valid.
  input wire s_axi_wready, // Data ready.
  input wire s_axi_bvalid, // Answer valid.
  input wire s_axi_bready, // Answer ready.
  input wire s_axi_rvalid, // Read valid.
  input wire s_axi_rready, // Read ready.
  input wire [31:0] s_axi_rdata, // Read data.
  input wire flash_cs_n, // Chip select.
  input wire flash_sck, // Serial clock.
  input wire [3:0] flash_io_out, // Line values.
  input wire [3:0] flash_io_oe_n // Line enables.
);
  reg [15:0] hi_q;
  reg [7:0] rise_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // The high-phase counter doubles as the edge detector for frame length.
  always @(posedge aclk) begin
    if (!aresetn || !flash_sck)
      hi_q <= 16'h0000;
    else
      hi_q <= hi_q + 16'h0001;
    if (!aresetn || flash_cs_n)
      rise_q <= 8'h00;
    else if (flash_sck && hi_q == 16'h0000)
      rise_q <= rise_q + 8'h01;
  end
  sequence s_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_frame_end;
    $rose(flash_cs_n);
  endsequence
  a_write_answer: assert property (s_both_taken |-> ##2 s_axi_bvalid)
    else $error("write answer missing");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed");
  a_sck_in_frame: assert property (flash_sck |-> !flash_cs_n)
    else $error("serial clock outside frame");
  a_sck_half: assert property ($fell(flash_sck) |-> hi_q == SCK_HALF)
    else $error("serial clock high phase wrong");
  a_io_hold: assert property (flash_sck && $past(flash_sck)
    |-> $stable(flash_io_out) && $stable(flash_io_oe_n))
    else $error("data changed while clock high");
  a_oe_legal: assert property (!flash_cs_n
    |-> flash_io_oe_n inside {4'h2, 4'h0, 4'hF})
    else $error("line enables illegal");
  a_frame_len: assert property (s_frame_end
    |-> rise_q inside {8'h02, 8'h04, 8'h08, 8'h0A, 8'h10, 8'h20, 8'h28})
    else $error("frame length illegal");
  a_cs_gap: assert property (s_frame_end |-> flash_cs_n [*2])
    else $error("chip select gap short");
endmodule
bind sfe_ctrl sfe_ctrl_chk #(.SCK_HALF(SCK_HALF), .CS_GAP(CS_GAP)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .flash_cs_n(flash_cs_n), .flash_sck(flash_sck),
  .flash_io_out(flash_io_out), .flash_io_oe_n(flash_io_oe_n));

/* File: testbench/sfe_flash_model.sv */
// Behavioural serial flash for the erase group, SPI mode 0.
// Assumes resolved data lines; holds no array and no protection bits.
`timescale 1ns/1ns
module sfe_flash_model (
  input wire cs_n, // Chip select.
  input wire sck, // Serial clock.
  input wire [3:0] io, // Resolved lines.
  input wire quad, // Four-line mode.
  input wire addr4, // Four-byte address set.
  input wire eval_ok, // Evaluation outcome.
  output reg [3:0] dq_out, // Drive values.
  output reg [3:0] dq_oe, // Drive enables, high drives.
  output reg [7:0] last_op, // Last accepted opcode.
  output reg [31:0] last_addr, // Its address.
  output reg [7:0] n_exec // Accepted operations.
);
  reg [39:0] sh = 40'h0;
  reg [7:0] op = 8'h00;
  reg [7:0] nb = 8'h00;
  reg [7:0] alen;
  reg [1:0] polls = 2'h0;
  reg write_enable_latch = 1'b0;
  reg write_in_progress = 1'b0;
  reg est = 1'b0;
  reg ers;
  reg whl;
  wire [7:0] st = (op == 8'h05) ? {6'h00, write_enable_latch, write_in_progress} : {5'h00, est, 2'h0};
  initial begin
    dq_oe = 4'h0;
    dq_out = 4'h0;
    last_op = 8'h00;
    last_addr = 32'h0;
    n_exec = 8'h00;
  end
  always @(negedge cs_n) nb = 8'h00;
  always @(posedge sck) if (!cs_n) begin
    sh = quad ? {sh[35:0], io} : {sh[38:0], io[0]};
    nb = nb + (quad ? 8'h04 : 8'h01);
    if (nb == 8'h08)
      op = sh[7:0];
  end
  // Status answers change on the falling edge and are released at once.
  always @(negedge sck) begin
    if (!cs_n && nb >= 8'h08 && nb < 8'h10 && (op == 8'h05 || op == 8'h07))
    begin
      dq_oe = quad ? 4'hF : 4'h2;
      dq_out = quad ? (nb == 8'h08 ? st[7:4] : st[3:0])
                    : {2'b00, st[8'd15 - nb], 1'b0};
    end else
      dq_oe = 4'h0;
  end
  always @(posedge cs_n) begin
    dq_oe = 4'h0;
    alen = (op == 8'h21 || op == 8'hDC || addr4) ? 8'h28 : 8'h20;
    whl = op == 8'h60 || op == 8'hC7;
    ers = whl || op == 8'h20 || op == 8'h21 || op == 8'hD8 || op == 8'hDC;
    if (op == 8'h06 && nb == 8'h08)
      write_enable_latch = 1'b1;
    else if (op == 8'h05 && nb == 8'h10 && polls != 2'h0) begin
      polls = polls - 2'h1;
      if (polls == 2'h0) begin
        write_in_progress = 1'b0;
        write_enable_latch = 1'b0;
      end
    end else if ((ers && write_enable_latch || op == 8'hD0) && !write_in_progress
                 && nb == (whl ? 8'h08 : alen)) begin
      // No array and no protection: every accepted erase counts as
      // permitted and fully done, so refusals and skips never occur.
      write_in_progress = 1'b1;
      write_enable_latch = 1'b1;
      polls = 2'h2;
      last_op = op;
      last_addr = whl ? 32'h0 : (alen == 8'h20) ? {8'h00, sh[23:0]}
                                                : sh[31:0];
      n_exec = n_exec + 8'h01;
      if (op == 8'hD0)
        est = eval_ok;
    end else if (ers)
      write_enable_latch = 1'b0;
  end
endmodule

/* File: testbench/tb.sv */
// Bench for sfe_ctrl: AXI-Lite orders, flash model on the pins.
// Assumes the design, the flash model and the checker are compiled first.
`timescale 1ns/1ns
`include "sfe_defines.vh"
module tb;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [7:0] awaddr = 8'h00;
  reg [7:0] araddr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg awvalid = 1'b0;
  reg wvalid = 1'b0;
  reg bready = 1'b0;
  reg arvalid = 1'b0;
  reg rready = 1'b0;
  reg quad = 1'b0;
  reg addr4 = 1'b0;
  reg eval_ok = 1'b0;
  reg tgl = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, cs_n, sck;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata, last_addr;
  wire [3:0] io_out, oe_n, m_out, m_oe, io_w;
  wire [7:0] last_op, n_exec;
  integer err_total = 0;
  integer comparisons = 0;
  always #2 aclk = ~aclk;
  always @(posedge aclk) tgl <= ~tgl;
  // Lines nobody drives toggle so a stale level is never mistaken for data.
  assign io_w = (~oe_n & io_out) | (oe_n & m_oe & m_out)
              | (oe_n & ~m_oe & {4{tgl}});
  sfe_ctrl #(.SCK_HALF(16'h0004), .CS_GAP(8'h02)) DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .flash_cs_n(cs_n), .flash_sck(sck),
    .flash_io_out(io_out), .flash_io_oe_n(oe_n), .flash_io_in(io_w));
  sfe_flash_model FM (.cs_n(cs_n), .sck(sck), .io(io_w), .quad(quad),
    .addr4(addr4), .eval_ok(eval_ok), .dq_out(m_out), .dq_oe(m_oe),
    .last_op(last_op), .last_addr(last_addr), .n_exec(n_exec));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task finish_test;
    begin
      $display("mismatches=%0d comparisons=%0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task tick(inout integer n);
    begin
      @(posedge aclk);
      n = n + 1;
      if (n > 5000) begin
        err_total = err_total + 1;
        finish_test;
      end
    end
  endtask
  task axi_wr(input [7:0] a, input [31:0] d, input [1:0] er);
    integer n;
    begin
      n = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!bvalid || n == 0) begin
        tick(n);
        if (awvalid && awready)
          awvalid <= 1'b0;
        if (wvalid && wready)
          wvalid <= 1'b0;
      end
      chk({30'h0, bresp}, {30'h0, er});
      bready <= 1'b0;
      @(posedge aclk);
    end
  endtask
  task axi_rd(input [7:0] a, output [31:0] d, input [1:0] er);
    integer n;
    begin
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!rvalid || n == 0) begin
        tick(n);
        if (arvalid && arready)
          arvalid <= 1'b0;
      end
      d = rdata;
      chk({30'h0, rresp}, {30'h0, er});
      rready <= 1'b0;
      @(posedge aclk);
    end
  endtask
  task reg_reset;
    reg [31:0] d;
    begin
      axi_rd(`SFE_REG_CFG, d, 2'b00);
      chk(d, 32'h0);
      axi_rd(`SFE_REG_STAT, d, 2'b00);
      chk(d, 32'h0);
      axi_rd(`SFE_REG_ADDR, d, 2'b00);
      chk(d, `SFE_ADDR_RST);
      axi_rd(8'h10, d, 2'b10);
      chk(d, 32'h0);
      axi_wr(8'h14, 32'hFFFF_FFFF, 2'b10);
      axi_wr(`SFE_REG_ADDR, 32'hA5A5_5A5A, 2'b00);
      axi_rd(`SFE_REG_ADDR, d, 2'b00);
      chk(d, 32'hA5A5_5A5A);
    end
  endtask
  task run_op(input [4:0] ctl, input q, input a4, input [7:0] eop,
      input [31:0] ea);
    integer n;
    reg [31:0] st;
    reg [7:0] cnt;
    begin
      n = 0;
      cnt = n_exec;
      quad <= q;
      addr4 <= a4;
      axi_wr(`SFE_REG_CFG, {30'h0, q, a4}, 2'b00);
      axi_wr(`SFE_REG_ADDR, 32'h1234_5678, 2'b00);
      axi_wr(`SFE_REG_CTRL, {27'h0, ctl}, 2'b00);
      st = 32'h0000_0001;
      while (st[`SFE_STAT_BUSY] || !st[`SFE_STAT_DONE]) begin
        tick(n);
        axi_rd(`SFE_REG_STAT, st, 2'b00);
      end
      chk(st & 32'h0000_FF03, 32'h0000_0002);
      chk({24'h0, last_op}, {24'h0, eop});
      chk(last_addr, ea);
      chk({24'h0, n_exec}, {24'h0, cnt + 8'h01});
      if (eop == `SFE_OPC_EVAL)
        chk(st & 32'h00FF_0004, eval_ok ? 32'h0004_0004 : 32'h0);
      axi_wr(`SFE_REG_STAT, 32'h0000_0002, 2'b00);
      axi_rd(`SFE_REG_STAT, st, 2'b00);
      chk(st & 32'h0000_0003, 32'h0);
    end
  endtask
  task erase_single;
    begin
      eval_ok <= 1'b1;
      run_op(5'h01, 1'b0, 1'b0, `SFE_OPC_SMALL, 32'h0034_5678);
      run_op(5'h09, 1'b0, 1'b0, `SFE_OPC_SMALL_W, 32'h1234_5678);
      run_op(5'h03, 1'b0, 1'b0, `SFE_OPC_SECT, 32'h0034_5678);
      run_op(5'h0B, 1'b0, 1'b0, `SFE_OPC_SECT_W, 32'h1234_5678);
      run_op(5'h05, 1'b0, 1'b0, `SFE_OPC_WHOLE, 32'h0);
      run_op(5'h15, 1'b0, 1'b0, `SFE_OPC_WHOLE_ALT, 32'h0);
      run_op(5'h07, 1'b0, 1'b0, `SFE_OPC_EVAL, 32'h0034_5678);
    end
  endtask
  task erase_quad;
    begin
      eval_ok <= 1'b0;
      run_op(5'h01, 1'b1, 1'b1, `SFE_OPC_SMALL, 32'h1234_5678);
      run_op(5'h03, 1'b1, 1'b1, `SFE_OPC_SECT, 32'h1234_5678);
      run_op(5'h05, 1'b1, 1'b0, `SFE_OPC_WHOLE, 32'h0);
      run_op(5'h07, 1'b1, 1'b1, `SFE_OPC_EVAL, 32'h1234_5678);
    end
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    reg_reset;
    erase_single;
    erase_quad;
    finish_test;
  end
endmodule
